// ### core/frtc_top.sv
// Free-running 16-bit timer counter with prescaler, buffered byte reads and overflow flag.
// Assumes a single core clock, synchronous pins and an AXI4-Lite master for software.
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps

module frtc_top
  import frtc_pkg::*;
#(
  parameter bit EXT_PIN_BONDED = 1'b1
)
(
  input  logic        CORE_CLK,
  input  logic        RST_B,
  input  logic        EXT_CLK_PIN,
  input  logic        HALT_MODE,
  input  logic        CPU_I_MASK,
  output logic        TIMER_IRQ,
  input  logic [7:0]  S_AXI_AWADDR,
  input  logic        S_AXI_AWVALID,
  output logic        S_AXI_AWREADY,
  input  logic [31:0] S_AXI_WDATA,
  input  logic [3:0]  S_AXI_WSTRB,
  input  logic        S_AXI_WVALID,
  output logic        S_AXI_WREADY,
  output logic [1:0]  S_AXI_BRESP,
  output logic        S_AXI_BVALID,
  input  logic        S_AXI_BREADY,
  input  logic [7:0]  S_AXI_ARADDR,
  input  logic        S_AXI_ARVALID,
  output logic        S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0]  S_AXI_RRESP,
  output logic        S_AXI_RVALID,
  input  logic        S_AXI_RREADY
);

  // ****************************************************
  // Sub-blocks
  // ****************************************************
  frtc_tick_if tk ();
  frtc_reg_if  rg ();

  frtc_presc #(.EXT_PIN_BONDED (EXT_PIN_BONDED)) u_presc
  (
    .clk     (CORE_CLK),
    .rst_b   (RST_B),
    .ext_pin (EXT_CLK_PIN),
    .tk      (tk.presc)
  );

  frtc_axil u_axil
  (
    .clk     (CORE_CLK),
    .rst_b   (RST_B),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .rg      (rg.slave)
  );

  // ****************************************************
  // State
  // ****************************************************
  logic [15:0]      cnt_r;
  logic [7:0]       low_buf_r;
  logic             latched_r;
  logic             ovf_flag_r;
  logic             clr_armed_r;
  logic [7:0]       ctrl1_r;
  logic [7:0]       ctrl2_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_en_r;
  logic             irq_r;

  logic             wr_lo;
  logic             reload;
  logic             ovf_evt;
  logic             rd_hi;
  logic             rd_lo;
  logic             main_lo_acc;
  logic             rd_status;
  logic [IRQ_W-1:0] irq_evt;
  logic             irq_nxt;

  assign tk.sel       = ctrl2_r[CTRL2_CS_LSB +: 2];
  assign tk.edge_rise = ctrl2_r[CTRL2_EDGE_BIT];
  // Only halt gates counting; wait mode has no input here
  assign tk.halt      = HALT_MODE;

  // ****************************************************
  // Access decode
  // ****************************************************
  assign wr_lo  = rg.wr_en && rg.wr_strb[0] && (rg.wr_addr == OFS_CNT_LO || rg.wr_addr == OFS_ALT_LO);
  assign reload = wr_lo;
  assign rd_hi  = rg.rd_en && (rg.rd_addr == OFS_CNT_HI || rg.rd_addr == OFS_ALT_HI);
  assign rd_lo  = rg.rd_en && (rg.rd_addr == OFS_CNT_LO || rg.rd_addr == OFS_ALT_LO);
  // Alternate low byte is deliberately absent here
  assign main_lo_acc = (rg.rd_en && rg.rd_addr == OFS_CNT_LO)
                    || (rg.wr_en && rg.wr_addr == OFS_CNT_LO);
  assign rd_status = rg.rd_en && rg.rd_addr == OFS_STATUS;
  assign ovf_evt   = tk.tick && !reload && cnt_r == CNT_MAX;

  // ****************************************************
  // Counter
  // ****************************************************
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      cnt_r <= CNT_RESET;
    else if (reload)
      cnt_r <= CNT_RESET;
    else if (tk.tick)
      cnt_r <= 16'(cnt_r + 16'h0001);
  end

  // ****************************************************
  // Low byte buffer for two-byte reads
  // ****************************************************
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      low_buf_r <= 8'h00;
      latched_r <= 1'b0;
    end
    else if (rd_hi && !latched_r)
    begin
      low_buf_r <= cnt_r[7:0];
      latched_r <= 1'b1;
    end
    else if (rd_lo)
    begin
      latched_r <= 1'b0;
    end
  end

  // ****************************************************
  // Overflow flag and its two-step clear
  // ****************************************************
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ovf_flag_r  <= 1'b0;
      clr_armed_r <= 1'b0;
    end
    else
    begin
      if (ovf_evt)
        ovf_flag_r <= 1'b1;
      else if (clr_armed_r && main_lo_acc)
        ovf_flag_r <= 1'b0;
      if (rd_status && ovf_flag_r)
        clr_armed_r <= 1'b1;
      else if (main_lo_acc || !ovf_flag_r)
        clr_armed_r <= 1'b0;
    end
  end

  // ****************************************************
  // Control registers
  // ****************************************************
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ctrl1_r <= CTRL_RESET;
      ctrl2_r <= CTRL_RESET;
    end
    else if (rg.wr_en && rg.wr_strb[0])
    begin
      if (rg.wr_addr == OFS_CTRL1)
        ctrl1_r <= rg.wr_data[7:0];
      if (rg.wr_addr == OFS_CTRL2)
        ctrl2_r <= rg.wr_data[7:0];
    end
  end

  // ****************************************************
  // Interrupt status, clear and enable
  // ****************************************************
  always_comb
  begin
    irq_evt                 = '0;
    irq_evt[IRQ_OVF_BIT]    = ovf_evt;
    irq_evt[IRQ_RELOAD_BIT] = reload;
  end

  // A new event wins over a clear in the same cycle
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      irq_stat_r <= '0;
    else if (rg.wr_en && rg.wr_strb[0] && rg.wr_addr == OFS_IRQ_CLR)
      irq_stat_r <= (irq_stat_r & ~rg.wr_data[IRQ_W-1:0]) | irq_evt;
    else
      irq_stat_r <= irq_stat_r | irq_evt;
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      irq_en_r <= '0;
    else if (rg.wr_en && rg.wr_strb[0] && rg.wr_addr == OFS_IRQ_EN)
      irq_en_r <= rg.wr_data[IRQ_W-1:0];
  end

  assign irq_nxt = (ovf_flag_r && ctrl1_r[CTRL1_OVF_IE] && !CPU_I_MASK)
                || (|(irq_stat_r & irq_en_r));

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      irq_r <= 1'b0;
    else
      irq_r <= irq_nxt;
  end

  assign TIMER_IRQ = irq_r;

  // ****************************************************
  // Read data and address errors
  // ****************************************************
  always_comb
  begin
    rg.rd_data = 32'h00000000;
    rg.rd_err  = 1'b0;
    case (rg.rd_addr)
      OFS_CNT_HI, OFS_ALT_HI: rg.rd_data[7:0] = cnt_r[15:8];
      OFS_CNT_LO, OFS_ALT_LO: rg.rd_data[7:0] = latched_r ? low_buf_r : cnt_r[7:0];
      OFS_STATUS:             rg.rd_data[STAT_OVF_BIT] = ovf_flag_r;
      OFS_CTRL1:              rg.rd_data[7:0] = ctrl1_r;
      OFS_CTRL2:              rg.rd_data[7:0] = ctrl2_r;
      OFS_IRQ_STAT:           rg.rd_data[IRQ_W-1:0] = irq_stat_r;
      OFS_IRQ_EN:             rg.rd_data[IRQ_W-1:0] = irq_en_r;
      OFS_IRQ_CLR:            rg.rd_data = 32'h00000000;
      default:                rg.rd_err = 1'b1;
    endcase
  end

  always_comb
  begin
    case (rg.wr_addr)
      OFS_CNT_HI, OFS_CNT_LO, OFS_ALT_HI, OFS_ALT_LO, OFS_STATUS,
      OFS_CTRL1, OFS_CTRL2, OFS_IRQ_STAT, OFS_IRQ_CLR, OFS_IRQ_EN: rg.wr_err = 1'b0;
      default:                                                     rg.wr_err = 1'b1;
    endcase
  end

  // ****************************************************
  // Checks
  // ****************************************************
  cnt_advance_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (tk.tick && !reload) |=> cnt_r == 16'($past(cnt_r) + 16'h0001))
    else $error("counter did not advance by one");

  cnt_reload_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    reload |=> cnt_r == CNT_RESET)
    else $error("low byte write did not reload counter");

  halt_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (HALT_MODE ##1 (HALT_MODE && !reload)) |=> $stable(cnt_r))
    else $error("counter moved during halt");

  ovf_set_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (tk.tick && !reload && cnt_r == CNT_MAX) |=> (ovf_flag_r && cnt_r == 16'h0000))
    else $error("wrap did not set overflow flag");

  ovf_keep_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (ovf_flag_r && !(clr_armed_r && main_lo_acc)) |=> ovf_flag_r)
    else $error("overflow flag cleared without two steps");

  alt_noclr_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (ovf_flag_r && rg.rd_en && rg.rd_addr == OFS_ALT_LO) |=> ovf_flag_r)
    else $error("alternate low read cleared overflow");

  hi_latch_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (rd_hi && !latched_r) |=> (latched_r && low_buf_r == $past(cnt_r[7:0])))
    else $error("high read did not latch low byte");

  buf_freeze_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (latched_r && !rd_lo) |=> (latched_r && $stable(low_buf_r)))
    else $error("latched low byte did not stay frozen");

  buf_read_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (rd_lo && latched_r) |-> rg.rd_data == {24'h000000, low_buf_r})
    else $error("low read did not return latched byte");

  low_unlatch_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    rd_lo |=> !latched_r)
    else $error("low read did not end the pair");

  live_low_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (rd_lo && !latched_r) |-> rg.rd_data == {24'h000000, cnt_r[7:0]})
    else $error("lone low read not live");

  irq_gate_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (ovf_flag_r && ctrl1_r[CTRL1_OVF_IE] && !CPU_I_MASK) |=> TIMER_IRQ)
    else $error("overflow interrupt not raised");

  // Interrupt must stay low when no enabled source is pending
  irq_quiet_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (!(ovf_flag_r && ctrl1_r[CTRL1_OVF_IE] && !CPU_I_MASK) && !(|(irq_stat_r & irq_en_r))) |=> !TIMER_IRQ)
    else $error("interrupt raised without enabled source");

  ovf_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (clr_armed_r && main_lo_acc && !ovf_evt) |=> !ovf_flag_r)
    else $error("two-step clear did not clear overflow");

  ovf_spurious_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (cnt_r != CNT_MAX && !ovf_flag_r) |=> !ovf_flag_r)
    else $error("overflow flag set without wrap");

endmodule

// ### core/frtc_pkg.sv
// Constants shared by the free-running timer counter block.
// Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
package frtc_pkg;

  // ****************************************************
  // Register byte offsets
  // ****************************************************
  localparam logic [7:0] OFS_CNT_HI   = 8'h00;
  localparam logic [7:0] OFS_CNT_LO   = 8'h04;
  localparam logic [7:0] OFS_ALT_HI   = 8'h08;
  localparam logic [7:0] OFS_ALT_LO   = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_CTRL1    = 8'h14;
  localparam logic [7:0] OFS_CTRL2    = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h20;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h24;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int STAT_OVF_BIT    = 0;
  localparam int CTRL1_OVF_IE    = 0;
  localparam int CTRL2_CS_LSB    = 0;
  localparam int CTRL2_EDGE_BIT  = 2;
  localparam int IRQ_OVF_BIT     = 0;
  localparam int IRQ_RELOAD_BIT  = 1;
  localparam int IRQ_W           = 2;

  // ****************************************************
  // Reset values and encodings
  // ****************************************************
  localparam logic [15:0] CNT_RESET  = 16'hFFFC;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [1:0]  CS_DIV2    = 2'h0;
  localparam logic [1:0]  CS_DIV4    = 2'h1;
  localparam logic [1:0]  CS_DIV8    = 2'h2;
  localparam logic [1:0]  CS_EXT     = 2'h3;
  localparam logic [2:0]  DIV_RESET  = 3'h0;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// ### core/frtc_if.sv
// Internal carriers between the timer core, its prescaler and its bus slave.
// Assumes all three run on the same core clock.
`timescale 1ns/1ps

interface frtc_tick_if;
  logic [1:0] sel;
  logic       edge_rise;
  logic       halt;
  logic       tick;
  modport presc (input sel, input edge_rise, input halt, output tick);
  modport core  (output sel, output edge_rise, output halt, input tick);
endinterface

interface frtc_reg_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_err;
  logic        rd_en;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_err;
  modport slave (output wr_en, output wr_addr, output wr_data, output wr_strb, input wr_err,
                 output rd_en, output rd_addr, input rd_data, input rd_err);
  modport regs  (input wr_en, input wr_addr, input wr_data, input wr_strb, output wr_err,
                 input rd_en, input rd_addr, output rd_data, output rd_err);
endinterface

// ### core/frtc_presc.sv
// Timer clock prescaler: core clock divided by 2, 4 or 8, or external pin edges.
// Assumes the external pin changes at most once per four core clocks.
`timescale 1ns/1ps

module frtc_presc
  import frtc_pkg::*;
#(
  parameter bit EXT_PIN_BONDED = 1'b1
)
(
  input  logic           clk,
  input  logic           rst_b,
  input  logic           ext_pin,
  frtc_tick_if.presc     tk
);

  logic [2:0] div_r;
  logic       sync1_r;
  logic       sync2_r;
  logic       sync3_r;
  logic       tick_r;
  logic       pin_lvl;
  logic       ext_edge;
  logic       tick_nxt;

  // Unbonded pin reads as one
  assign pin_lvl = EXT_PIN_BONDED ? ext_pin : 1'b1;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      sync3_r <= 1'b1;
    end
    else
    begin
      sync1_r <= pin_lvl;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Chosen edge of the synchronised pin
  assign ext_edge = tk.edge_rise ? (sync2_r & ~sync3_r) : (~sync2_r & sync3_r);

  always_comb
  begin
    case (tk.sel)
      CS_DIV2: tick_nxt = div_r[0];
      CS_DIV4: tick_nxt = &div_r[1:0];
      CS_DIV8: tick_nxt = &div_r;
      CS_EXT:  tick_nxt = ext_edge;
      default: tick_nxt = 1'b0;
    endcase
  end

  // Divider holds in halt; reset value makes twin timers run in step
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_r  <= DIV_RESET;
      tick_r <= 1'b0;
    end
    else if (tk.halt)
    begin
      tick_r <= 1'b0;
    end
    else
    begin
      div_r  <= 3'(div_r + 3'h1);
      tick_r <= tick_nxt;
    end
  end

  assign tk.tick = tick_r;

  div2_rate_a: assert property (@(posedge clk) disable iff (!rst_b)
    (tk.sel == CS_DIV2 && $stable(tk.sel) && !tk.halt && tick_r) |=> !tick_r ##1 (tick_r || tk.halt))
    else $error("divide by two tick spacing wrong");

endmodule

// ### core/frtc_axil.sv
// AXI4-Lite slave front end: turns bus transfers into one-cycle register strobes.
// Assumes one write and one read at most in flight; answers one cycle after commit.
`timescale 1ns/1ps

module frtc_axil
  import frtc_pkg::*;
(
  input  logic        clk,
  input  logic        rst_b,
  input  logic [7:0]  awaddr,
  input  logic        awvalid,
  output logic        awready,
  input  logic [31:0] wdata,
  input  logic [3:0]  wstrb,
  input  logic        wvalid,
  output logic        wready,
  output logic [1:0]  bresp,
  output logic        bvalid,
  input  logic        bready,
  input  logic [7:0]  araddr,
  input  logic        arvalid,
  output logic        arready,
  output logic [31:0] rdata,
  output logic [1:0]  rresp,
  output logic        rvalid,
  input  logic        rready,
  frtc_reg_if.slave   rg
);

  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        aw_full_r;
  logic        w_full_r;
  logic        commit;

  assign commit = aw_full_r && w_full_r && !bvalid;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awaddr_r  <= awaddr;
        aw_full_r <= 1'b1;
        awready   <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
        w_full_r <= 1'b1;
        wready   <= 1'b0;
      end
      if (commit)
      begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= rg.wr_err ? RESP_SLVERR : RESP_OKAY;
      end
      else if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rg.rd_data;
      rresp   <= rg.rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  assign rg.wr_en   = commit;
  assign rg.wr_addr = awaddr_r;
  assign rg.wr_data = wdata_r;
  assign rg.wr_strb = wstrb_r;
  assign rg.rd_en   = arvalid && arready;
  assign rg.rd_addr = araddr;

endmodule

// ### verif/frtc_ext_src.sv
// External timer clock source model.
// Assumes the bench calls toggle() only while the pin is the timer clock.
`timescale 1ns/1ps

module frtc_ext_src
(
  input  logic clk,
  output logic pin
);
  initial pin = 1'b0;

  // Flips the pin n times, six core clocks apart
  task automatic toggle(input int n);
    repeat (n)
    begin
      @(posedge clk);
      pin <= ~pin;
      repeat (5) @(posedge clk);
    end
  endtask
endmodule

// ### verif/free_running_timer_counter_bench.sv
// Self-checking bench for the free-running timer counter.
// Assumes frtc_pkg, the interfaces and the design modules are compiled first.
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("FAIL %0t: value mismatch, got %h exp %h", $time, (got), (exp)); \
    end \
  end

module free_running_timer_counter_bench
  import frtc_pkg::*;
;
  logic        core_clk, rst_b, ext_clk_pin, halt_mode, cpu_i_mask, timer_irq;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] cnt;
  int          fail_count, tests_run;
  logic [31:0] rdata_twin;

  frtc_top dut (.CORE_CLK(core_clk), .RST_B(rst_b), .EXT_CLK_PIN(ext_clk_pin), .HALT_MODE(halt_mode),
    .CPU_I_MASK(cpu_i_mask), .TIMER_IRQ(timer_irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  frtc_ext_src src (.clk(core_clk), .pin(ext_clk_pin));

  // Twin timer with the clock pin unbonded, fed by the same bus traffic
  frtc_top #(.EXT_PIN_BONDED(1'b0)) twin (.CORE_CLK(core_clk), .RST_B(rst_b), .EXT_CLK_PIN(ext_clk_pin),
    .HALT_MODE(halt_mode), .CPU_I_MASK(cpu_i_mask), .TIMER_IRQ(), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(),
    .S_AXI_BRESP(), .S_AXI_BVALID(), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(), .S_AXI_RDATA(rdata_twin), .S_AXI_RRESP(), .S_AXI_RVALID(), .S_AXI_RREADY(rready));

  // ****************************************************
  // Clock, time-zero values and bus tasks
  // ****************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial
  begin
    {rst_b, cpu_i_mask, halt_mode} = 3'b011;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    fail_count = 0;
    tests_run = 0;
  end

  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'b111;
    n = 0;
    do
    begin
      @(posedge core_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
    end
    while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    `CHK(bresp, er)
    if (n >= 50)
    begin
      fail_count++;
      wrap_up();
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    n = 0;
    do
    begin
      @(posedge core_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
    end
    while (rvalid !== 1'b1 && n < 50);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50)
    begin
      fail_count++;
      wrap_up();
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [1:0] r;
    axr(a, d, r);
    `CHK(d, e)
    `CHK(r, RESP_OKAY)
  endtask

  task automatic rcnt(output logic [15:0] c);
    logic [1:0] r;
    axr(OFS_CNT_HI, d, r);
    c[15:8] = d[7:0];
    axr(OFS_CNT_LO, d, r);
    c[7:0] = d[7:0];
  endtask

  task automatic run(input int n);
    @(posedge core_clk);
    halt_mode <= 1'b0;
    repeat (n) @(posedge core_clk);
    halt_mode <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask

  // ****************************************************
  // Test sequence
  // ****************************************************
  initial
  begin
    logic [1:0] r;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    rchk(OFS_CNT_HI, 32'hFF);
    rchk(OFS_CNT_LO, 32'hFC);
    rchk(OFS_CTRL2, 32'h0);
    rchk(OFS_STATUS, 32'h0);
    axr(8'h30, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
    axw(8'h30, 32'h1, RESP_SLVERR);
    axw(OFS_CNT_HI, 32'h12, RESP_OKAY);
    rchk(OFS_ALT_HI, 32'hFF);
    $display("reset and map test done");

    rchk(OFS_CNT_HI, 32'hFF);
    run(10);
    rchk(OFS_CNT_HI, 32'h00);
    rchk(OFS_CNT_LO, 32'hFC);
    axr(OFS_CNT_LO, d, r);
    `CHK(d <= 32'h2, 1'b1)
    rchk(OFS_STATUS, 32'h1);
    $display("buffered read test done");

    axw(OFS_CTRL1, 32'h1, RESP_OKAY);
    repeat (3) @(posedge core_clk);
    `CHK(timer_irq, 1'b0)
    cpu_i_mask <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK(timer_irq, 1'b1)
    rchk(OFS_STATUS, 32'h1);
    rchk(OFS_ALT_LO, 32'h01);
    rchk(OFS_STATUS, 32'h1);
    rchk(OFS_CNT_LO, 32'h01);
    rchk(OFS_STATUS, 32'h0);
    repeat (3) @(posedge core_clk);
    `CHK(timer_irq, 1'b0)
    $display("overflow clear test done");

    axw(OFS_ALT_LO, 32'h55, RESP_OKAY);
    rcnt(cnt);
    `CHK(cnt, CNT_RESET)
    rchk(OFS_IRQ_STAT, 32'h3);
    axw(OFS_IRQ_EN, 32'h2, RESP_OKAY);
    repeat (3) @(posedge core_clk);
    `CHK(timer_irq, 1'b1)
    axw(OFS_IRQ_CLR, 32'h3, RESP_OKAY);
    repeat (3) @(posedge core_clk);
    `CHK(timer_irq, 1'b0)
    rchk(OFS_IRQ_STAT, 32'h0);
    axw(OFS_IRQ_EN, 32'h0, RESP_OKAY);
    $display("reload and event test done");

    for (int cs = 0; cs < 3; cs++)
    begin
      axw(OFS_CTRL2, 32'(cs), RESP_OKAY);
      axw(OFS_CNT_LO, 32'h0, RESP_OKAY);
      run(8 << (cs + 1));
      rcnt(cnt);
      cnt = cnt - CNT_RESET;
      `CHK(cnt >= 16'd7 && cnt <= 16'd9, 1'b1)
      `CHK(rdata_twin, rdata)
    end
    $display("prescaler test done");

    halt_mode <= 1'b0;
    axw(OFS_CTRL2, 32'h7, RESP_OKAY);
    axw(OFS_CNT_LO, 32'h0, RESP_OKAY);
    src.toggle(6);
    repeat (8) @(posedge core_clk);
    rcnt(cnt);
    `CHK(cnt, CNT_MAX)
    `CHK(rdata_twin, 32'hFC)
    axw(OFS_CTRL2, 32'h3, RESP_OKAY);
    src.toggle(4);
    repeat (8) @(posedge core_clk);
    rcnt(cnt);
    `CHK(cnt, 16'h0001)
    $display("external clock test done");
    wrap_up();
  end
endmodule
